// [verilog/gcs_pkg.sv]
// Constants and types for the bus controller command sequencer
package gcs_pkg;
    localparam logic [7:0] GCS_LLO = 8'h11;
    localparam logic [7:0] GCS_GTL = 8'h01;
    localparam logic [7:0] GCS_UNL = 8'h3f;
    localparam logic [7:0] GCS_LAD_BASE = 8'h20;
    localparam logic [4:0] GCS_ADDR_MAX = 5'h1e;
    localparam logic [4:0] GCS_ADDR_DEF = 5'h15;
    localparam logic [15:0] GCS_CFG_DEF = 16'h0000;
    localparam logic [7:0] GCS_TERM_DEF = 8'h0a;
    localparam int GCS_BIT_ATN = 0;
    localparam int GCS_BIT_EOI = 1;
    localparam int GCS_BIT_SRQ = 2;
    localparam int GCS_BIT_IFC = 3;
    localparam int GCS_BIT_REN = 4;
    localparam int GCS_BIT_DAV = 5;
    localparam int GCS_BIT_NRFD = 6;
    localparam int GCS_BIT_NDAC = 7;
    typedef enum logic [3:0] {
        GCS_IDLE = 4'h0,
        GCS_LOAD = 4'h1,
        GCS_WAIT_RDY = 4'h3,
        GCS_DAV_ON = 4'h2,
        GCS_WAIT_ACC = 4'h6,
        GCS_DAV_OFF = 4'h7,
        GCS_NEXT = 4'h5,
        GCS_STBY = 4'h4
    } gcs_state_e;
    typedef enum logic [2:0] {
        GCS_SEQ_NONE = 3'h0,
        GCS_SEQ_LLO = 3'h1,
        GCS_SEQ_GTL = 3'h2,
        GCS_SEQ_OUT = 3'h3
    } gcs_seq_e;
endpackage : gcs_pkg

// [verilog/gcs_sync.sv]
// Two-stage synchroniser for the bus input lines
`timescale 1ns/1ns
`default_nettype none
module gcs_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage1 <= '0;
            q_out <= '0;
        end else begin
            stage1 <= d_in;
            q_out <= stage1;
        end
    end
endmodule : gcs_sync
`default_nettype wire

// [verilog/gcs_ctrl.sv]
// Controller command sequencer: commands, byte handshake and line snapshot
`timescale 1ns/1ns
`default_nettype none
module gcs_ctrl
    import gcs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    // Host commands, one-cycle pulses, taken only when idle, except take-control, taken only in standby
    input wire logic init_cmd_in,
    input wire logic [4:0] init_addr_in,
    input wire logic [15:0] init_config_in,
    input wire logic [7:0] init_term_in,
    input wire logic go_standby_cmd_in,
    input wire logic take_control_cmd_in,
    input wire logic lockout_cmd_in,
    input wire logic go_local_cmd_in,
    input wire logic output_string_cmd_in,
    input wire logic signed [7:0] target_primary_address_in,
    // String bytes from the host
    input wire logic str_valid_in,
    input wire logic [7:0] str_data_in,
    input wire logic str_last_in,
    output logic str_ready_out,
    // Bus lines, true means asserted
    input wire logic atn_in,
    input wire logic eoi_in,
    input wire logic srq_in,
    input wire logic ifc_in,
    input wire logic ren_in,
    input wire logic dav_in,
    input wire logic nrfd_in,
    input wire logic ndac_in,
    output logic atn_out,
    output logic ren_out,
    output logic dav_out,
    output logic eoi_out,
    output logic [7:0] dio_out,
    output logic dio_oe_out,
    output logic shadow_out,
    output logic active_out,
    output logic busy_out,
    output logic [4:0] own_bus_address_out,
    output logic [15:0] config_word_out,
    output logic [7:0] bus_line_snapshot_out
);
    // ======================================================
    // Input synchronisers
    logic [7:0] raw_lines;
    logic [7:0] sync_lines;
    assign raw_lines = {ndac_in, nrfd_in, dav_in, ren_in, ifc_in, srq_in, eoi_in, atn_in};
    gcs_sync #(.WIDTH(8)) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .d_in(raw_lines),
        .q_out(sync_lines)
    );

    function automatic logic addr_ok(input logic signed [7:0] a);
        addr_ok = (a >= 8'sd0) && (a <= $signed({3'h0, GCS_ADDR_MAX}));
    endfunction : addr_ok

    // ======================================================
    // Sequencer state
    gcs_state_e state, next_state;
    gcs_seq_e seq, next_seq;
    logic [1:0] step, next_step;
    logic [4:0] tgt, next_tgt;
    logic [7:0] byte_q, next_byte_q;
    logic byte_cmd, next_byte_cmd;
    logic byte_end, next_byte_end;
    logic in_str, next_in_str;
    logic next_atn, next_ren, next_dav, next_eoi, next_oe, next_shadow, next_active;
    logic [4:0] next_addr;
    logic [15:0] next_cfg;
    logic [7:0] term, next_term;
    logic [7:0] next_snap;
    logic next_str_ready;

    always_comb begin
        next_state = state;
        next_seq = seq;
        next_step = step;
        next_tgt = tgt;
        next_byte_q = byte_q;
        next_byte_cmd = byte_cmd;
        next_byte_end = byte_end;
        next_in_str = in_str;
        next_atn = atn_out;
        next_ren = ren_out;
        next_dav = dav_out;
        next_eoi = eoi_out;
        next_oe = dio_oe_out;
        next_shadow = shadow_out;
        next_active = active_out;
        next_addr = own_bus_address_out;
        next_cfg = config_word_out;
        next_term = term;
        next_str_ready = 1'b0;
        // Inner-side view: REN always, ATN while active and DAV while data is driven read back our own drive; EOI reads the line
        next_snap = sync_lines;
        next_snap[GCS_BIT_ATN] = active_out ? atn_out : sync_lines[GCS_BIT_ATN];
        next_snap[GCS_BIT_REN] = ren_out;
        next_snap[GCS_BIT_DAV] = dio_oe_out ? dav_out : sync_lines[GCS_BIT_DAV];
        case (state)
            GCS_IDLE: begin
                if (init_cmd_in) begin
                    // Out-of-range address keeps the previous one
                    if (init_addr_in <= GCS_ADDR_MAX) begin
                        next_addr = init_addr_in;
                    end
                    next_cfg = init_config_in;
                    next_term = init_term_in;
                end else if (go_standby_cmd_in && active_out) begin
                    next_atn = 1'b0;
                    next_active = 1'b0;
                    next_shadow = 1'b1;
                    next_state = GCS_STBY;
                end else if (lockout_cmd_in && active_out) begin
                    next_seq = GCS_SEQ_LLO;
                    next_step = 2'h0;
                    next_state = GCS_LOAD;
                end else if (go_local_cmd_in && active_out) begin
                    if (addr_ok(target_primary_address_in)) begin
                        next_tgt = target_primary_address_in[4:0];
                        next_seq = GCS_SEQ_GTL;
                        next_step = 2'h0;
                        next_state = GCS_LOAD;
                    end
                    next_ren = 1'b0;
                end else if (output_string_cmd_in && active_out) begin
                    // String bytes are owed until the host marks the last one
                    next_in_str = 1'b1;
                    next_tgt = target_primary_address_in[4:0];
                    next_seq = GCS_SEQ_OUT;
                    // Skip addressing for current listeners
                    next_step = addr_ok(target_primary_address_in) ? 2'h0 : 2'h2;
                    next_state = GCS_LOAD;
                end
            end
            GCS_LOAD: begin
                next_byte_end = 1'b0;
                next_byte_cmd = 1'b1;
                next_state = GCS_WAIT_RDY;
                case (step)
                    2'h0: next_byte_q = (seq == GCS_SEQ_LLO) ? GCS_LLO : GCS_UNL;
                    2'h1: next_byte_q = GCS_LAD_BASE | {3'h0, tgt};
                    default: begin
                        if (seq == GCS_SEQ_GTL) begin
                            next_byte_q = GCS_GTL;
                        end else if (str_valid_in) begin
                            next_byte_cmd = 1'b0;
                            next_byte_q = str_data_in;
                            next_in_str = ~str_last_in;
                            next_str_ready = 1'b1;
                        end else if (in_str) begin
                            // Host stalled mid-string: wait, never send the terminator early
                            next_byte_cmd = 1'b0;
                            next_state = GCS_LOAD;
                        end else begin
                            next_byte_cmd = 1'b0;
                            next_byte_q = term;
                            next_byte_end = 1'b1;
                        end
                    end
                endcase
                next_atn = next_byte_cmd;
                next_oe = (next_state == GCS_WAIT_RDY);
            end
            GCS_WAIT_RDY: begin
                next_dav = 1'b0;
                if (!sync_lines[GCS_BIT_NRFD]) begin
                    next_dav = 1'b1;
                    next_eoi = byte_end;
                    next_state = GCS_DAV_ON;
                end
            end
            GCS_DAV_ON: begin
                next_state = GCS_WAIT_ACC;
            end
            GCS_WAIT_ACC: begin
                if (!sync_lines[GCS_BIT_NDAC]) begin
                    next_dav = 1'b0;
                    next_eoi = 1'b0;
                    next_state = GCS_DAV_OFF;
                end
            end
            GCS_DAV_OFF: begin
                next_oe = 1'b0;
                next_state = GCS_NEXT;
            end
            GCS_NEXT: begin
                next_state = GCS_IDLE;
                if (seq == GCS_SEQ_OUT && step == 2'h2 && !byte_end) begin
                    next_step = 2'h2;
                    next_state = GCS_LOAD;
                end else if (seq != GCS_SEQ_LLO && step != 2'h2) begin
                    next_step = step + 2'h1;
                    next_state = GCS_LOAD;
                end
                if (next_state == GCS_IDLE) begin
                    next_seq = GCS_SEQ_NONE;
                    next_atn = 1'b0;
                end
            end
            GCS_STBY: begin
                // Only take-control leaves standby
                if (take_control_cmd_in) begin
                    next_atn = 1'b1;
                    next_active = 1'b1;
                    next_shadow = 1'b0;
                    next_state = GCS_IDLE;
                end
            end
            default: next_state = GCS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= GCS_IDLE;
            seq <= GCS_SEQ_NONE;
            step <= 2'h0;
            tgt <= 5'h00;
            byte_q <= 8'h00;
            byte_cmd <= 1'b0;
            byte_end <= 1'b0;
            in_str <= 1'b0;
            atn_out <= 1'b0;
            ren_out <= 1'b0;
            dav_out <= 1'b0;
            eoi_out <= 1'b0;
            dio_oe_out <= 1'b0;
            shadow_out <= 1'b0;
            active_out <= 1'b1;
            own_bus_address_out <= GCS_ADDR_DEF;
            config_word_out <= GCS_CFG_DEF;
            term <= GCS_TERM_DEF;
            bus_line_snapshot_out <= 8'h00;
            str_ready_out <= 1'b0;
        end else begin
            state <= next_state;
            seq <= next_seq;
            step <= next_step;
            tgt <= next_tgt;
            byte_q <= next_byte_q;
            byte_cmd <= next_byte_cmd;
            byte_end <= next_byte_end;
            in_str <= next_in_str;
            atn_out <= next_atn;
            ren_out <= next_ren;
            dav_out <= next_dav;
            eoi_out <= next_eoi;
            dio_oe_out <= next_oe;
            shadow_out <= next_shadow;
            active_out <= next_active;
            own_bus_address_out <= next_addr;
            config_word_out <= next_cfg;
            term <= next_term;
            bus_line_snapshot_out <= next_snap;
            str_ready_out <= next_str_ready;
        end
    end

    assign dio_out = byte_q;
    assign busy_out = (state != GCS_IDLE);

    // ======================================================
    // Checks
    default clocking cb_chk @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_dav_oe; dav_out |-> dio_oe_out; endproperty
    a_dav_oe: assert property (p_dav_oe) else $error("dav without data drive");
    property p_dav_hold; state == GCS_WAIT_ACC && sync_lines[GCS_BIT_NDAC] |=> dav_out; endproperty
    a_dav_hold: assert property (p_dav_hold) else $error("dav dropped early");
    property p_stby; state == GCS_STBY |-> !atn_out && shadow_out && !active_out; endproperty
    a_stby: assert property (p_stby) else $error("standby outputs wrong");
    property p_stby_stay; state == GCS_STBY && !take_control_cmd_in |=> state == GCS_STBY; endproperty
    a_stby_stay: assert property (p_stby_stay) else $error("standby left");
    property p_llo; state == GCS_WAIT_RDY && seq == GCS_SEQ_LLO |-> atn_out && dio_out == GCS_LLO;
    endproperty
    a_llo: assert property (p_llo) else $error("lockout byte wrong");
    property p_snap; 1'b1 |=> bus_line_snapshot_out[GCS_BIT_IFC] == $past(sync_lines[GCS_BIT_IFC]);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot ifc bit wrong");
    c_stby: cover property (state == GCS_STBY);
    c_llo: cover property (state == GCS_WAIT_RDY && seq == GCS_SEQ_LLO);
    c_term: cover property (state == GCS_DAV_ON && seq == GCS_SEQ_OUT && byte_end);
endmodule : gcs_ctrl
`default_nettype wire

// [verif/gcs_listener.sv]
// Bus listener model for the command sequencer bench
`timescale 1ns/1ns
`default_nettype none
module gcs_listener #(
    parameter logic [4:0] MY_ADDR = 5'h04
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic slow_in,
    input wire logic dav_in,
    input wire logic atn_in,
    input wire logic eoi_in,
    input wire logic [7:0] dio_in,
    output logic nrfd_out,
    output logic ndac_out,
    output logic got_out,
    output logic [9:0] rec_out,
    output logic locked_out
);
    logic armed;
    logic listening;
    int wait_cnt;
    // ==========================================
    // Handshake, stalls 6 cycles when slow
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nrfd_out <= 1'b0;
            ndac_out <= 1'b1;
            got_out <= 1'b0;
            rec_out <= '0;
            wait_cnt <= 0;
        end else begin
            got_out <= 1'b0;
            if (wait_cnt != 0) begin
                wait_cnt <= wait_cnt - 1;
            end else if (dav_in && !nrfd_out) begin
                nrfd_out <= 1'b1;
                got_out <= 1'b1;
                rec_out <= {atn_in, eoi_in, dio_in};
                wait_cnt <= slow_in ? 6 : 1;
            end else if (dav_in && ndac_out) begin
                ndac_out <= 1'b0;
            end else if (!dav_in && !ndac_out) begin
                ndac_out <= 1'b1;
                wait_cnt <= slow_in ? 6 : 1;
            end else if (!dav_in && nrfd_out) begin
                nrfd_out <= 1'b0;
            end
        end
    end
    // ==========================================
    // Local and lockout state of this device
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            armed <= 1'b0;
            listening <= 1'b0;
            locked_out <= 1'b0;
        end else if (got_out && rec_out[9]) begin
            if (rec_out[7:0] == 8'h11) armed <= 1'b1;
            if (rec_out[7:0] == 8'h3f) listening <= 1'b0;
            if (rec_out[7:0] == (8'h20 | {3'h0, MY_ADDR})) begin
                listening <= 1'b1;
                locked_out <= armed;
            end
            if (rec_out[7:0] == 8'h01 && listening) locked_out <= 1'b0;
        end
    end
endmodule : gcs_listener
`default_nettype wire

// [verif/gcs_ctrl_test.sv]
// Self-checking bench for the command sequencer
`timescale 1ns/1ns
`default_nettype none
module gcs_ctrl_test;
    import gcs_pkg::*;
    typedef struct packed {
        logic [2:0] code;
        logic [7:0] addr;
        logic [2:0] n;
        logic [49:0] e;
    } gcs_row_s;
    logic clk_in, rstn_in, init_cmd_in, go_standby_cmd_in, take_control_cmd_in, lockout_cmd_in;
    logic go_local_cmd_in, output_string_cmd_in, str_valid_in, str_last_in, srq_in, ifc_in, slow;
    logic [4:0] init_addr_in, own_bus_address_out;
    logic [15:0] init_config_in, config_word_out;
    logic [7:0] init_term_in, str_data_in, dio_out, bus_line_snapshot_out;
    logic signed [7:0] target_primary_address_in;
    logic str_ready_out, atn_out, ren_out, dav_out, eoi_out, dio_oe_out, shadow_out;
    logic active_out, busy_out, nrfd, ndac, got, locked;
    logic [9:0] rec;
    logic [9:0] q[$];
    int bad_count, comparisons;
    gcs_row_s rows [6] = '{
        '{3'd0, 8'h00, 3'd1, {10'h211, 40'h0}},
        '{3'd1, 8'h04, 3'd3, {10'h23f, 10'h224, 10'h201, 20'h0}},
        '{3'd1, 8'h1e, 3'd3, {10'h23f, 10'h23e, 10'h201, 20'h0}},
        '{3'd1, 8'hff, 3'd0, 50'h0},
        '{3'd1, 8'h1f, 3'd0, 50'h0},
        '{3'd1, 8'h80, 3'd0, 50'h0}};
    // ==========================================
    // Design, listener and clock
    gcs_ctrl DUT (.clk_in, .rstn_in, .init_cmd_in, .init_addr_in, .init_config_in,
        .init_term_in, .go_standby_cmd_in, .take_control_cmd_in, .lockout_cmd_in,
        .go_local_cmd_in, .output_string_cmd_in, .target_primary_address_in,
        .str_valid_in, .str_data_in, .str_last_in, .str_ready_out,
        .atn_in(atn_out), .eoi_in(eoi_out), .srq_in, .ifc_in, .ren_in(ren_out),
        .dav_in(dav_out), .nrfd_in(nrfd), .ndac_in(ndac), .atn_out, .ren_out, .dav_out,
        .eoi_out, .dio_out, .dio_oe_out, .shadow_out, .active_out, .busy_out,
        .own_bus_address_out, .config_word_out, .bus_line_snapshot_out);
    gcs_listener PEER (.clk_in, .rstn_in, .slow_in(slow), .dav_in(dav_out),
        .atn_in(atn_out), .eoi_in(eoi_out), .dio_in(dio_out), .nrfd_out(nrfd),
        .ndac_out(ndac), .got_out(got), .rec_out(rec), .locked_out(locked));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    always @(posedge clk_in) if (got === 1'b1) q.push_back(rec);
    // ==========================================
    // Shared tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic fire(input logic [2:0] c, input logic signed [7:0] a);
        target_primary_address_in = a;
        case (c)
            3'd0: lockout_cmd_in = 1'b1;
            3'd1: go_local_cmd_in = 1'b1;
            3'd2: output_string_cmd_in = 1'b1;
            3'd3: go_standby_cmd_in = 1'b1;
            3'd4: take_control_cmd_in = 1'b1;
            default: init_cmd_in = 1'b1;
        endcase
        tick(1);
        {lockout_cmd_in, go_local_cmd_in, output_string_cmd_in} = '0;
        {go_standby_cmd_in, take_control_cmd_in, init_cmd_in} = '0;
    endtask : fire
    task automatic wait_idle;
        int i;
        tick(2);
        for (i = 0; i < 3000 && busy_out !== 1'b0; i++) tick(1);
        if (i == 3000) begin
            check("idle timeout", 16'h1, 16'h0);
            test_done();
        end
    endtask : wait_idle
    task automatic expect_q(input logic [2:0] n, input logic [49:0] e);
        check("byte count", 16'(q.size()), 16'(n));
        for (int k = 0; k < n; k++) check("byte", 16'(q[k]), 16'(e[49-10*k -: 10]));
        q.delete();
    endtask : expect_q
    task automatic send(input logic signed [7:0] a, input logic [7:0] b[$]);
        int i;
        fire(3'd2, a);
        for (int k = 0; k < b.size(); k++) begin
            str_valid_in = 1'b1;
            str_data_in = b[k];
            str_last_in = (k == b.size() - 1);
            i = 0;
            do begin
                tick(1);
                i++;
            end while (str_ready_out !== 1'b1 && i < 3000);
            if (i >= 3000) begin
                check("ready timeout", 16'h1, 16'h0);
                test_done();
            end
        end
        str_valid_in = 1'b0;
        str_last_in = 1'b0;
        wait_idle();
    endtask : send
    // ==========================================
    // Main sequence
    initial begin
        {init_cmd_in, go_standby_cmd_in, take_control_cmd_in, lockout_cmd_in} = '0;
        {go_local_cmd_in, output_string_cmd_in, str_valid_in, str_last_in} = '0;
        {srq_in, ifc_in, slow, init_addr_in, init_config_in, str_data_in} = '0;
        init_term_in = 8'h0d;
        target_primary_address_in = '0;
        rstn_in = 1'b0;
        tick(3);
        rstn_in = 1'b1;
        tick(3);
        check("active", 16'(active_out), 16'h1);
        check("own addr", 16'(own_bus_address_out), 16'h15);
        check("config", config_word_out, 16'h0);
        $display("test reset done");
        for (int r = 0; r < 6; r++) begin
            fire(rows[r].code, $signed(rows[r].addr));
            wait_idle();
            expect_q(rows[r].n, rows[r].e);
            if (rows[r].code == 3'd1) check("ren", 16'(ren_out), 16'h0);
        end
        check("locked after gtl", 16'(locked), 16'h0);
        $display("test table done");
        init_addr_in = 5'h00;
        init_config_in = 16'h0700;
        fire(3'd5, 8'sh00);
        wait_idle();
        check("own addr", 16'(own_bus_address_out), 16'h0);
        check("config", config_word_out, 16'h0700);
        init_addr_in = 5'h1f;
        fire(3'd5, 8'sh00);
        wait_idle();
        check("own addr kept", 16'(own_bus_address_out), 16'h0);
        $display("test init done");
        slow = 1'b1;
        send(8'sh04, '{8'h41, 8'h42});
        expect_q(3'd5, {10'h23f, 10'h224, 10'h041, 10'h042, 10'h10d});
        check("locked again", 16'(locked), 16'h1);
        send(-8'sh01, '{8'h43});
        expect_q(3'd2, {10'h043, 10'h10d, 30'h0});
        slow = 1'b0;
        $display("test output done");
        fire(3'd3, 8'sh00);
        tick(1);
        check("active", 16'(active_out), 16'h0);
        check("atn", 16'(atn_out), 16'h0);
        check("shadow", 16'(shadow_out), 16'h1);
        fire(3'd0, 8'sh00);
        tick(20);
        expect_q(3'd0, 50'h0);
        fire(3'd4, 8'sh00);
        tick(1);
        check("active", 16'(active_out), 16'h1);
        $display("test standby done");
        {srq_in, ifc_in} = 2'b11;
        tick(4);
        check("snapshot", 16'(bus_line_snapshot_out & 8'h0c), 16'h0c);
        check("snap ndac", 16'(bus_line_snapshot_out[7]), 16'(ndac));
        {srq_in, ifc_in} = 2'b00;
        tick(4);
        check("snapshot", 16'(bus_line_snapshot_out & 8'h0c), 16'h0);
        $display("test snapshot done");
        test_done();
    end
endmodule : gcs_ctrl_test
`default_nettype wire
